// ### hdl/lpwd_access_check.sv
// Presence, null page and write permission decision for one access
`timescale 1ns/100ps
`default_nettype none
module lpwd_access_check import lpwd_pkg::*; (
    input  wire logic i_present,
    input  wire logic i_writable,
    input  wire logic i_null_page,
    input  wire logic i_is_write,
    input  wire logic i_is_super,
    input  wire logic i_wpe,
    output logic      o_not_present,
    output logic      o_null_cpl,
    output logic      o_wr_denied,
    output logic      o_issue
);
    always_comb begin
        o_not_present = ~i_present;
        o_null_cpl    = i_present & i_null_page;
        // write permission; supervisor only under protection
        o_wr_denied   = i_present & ~i_null_page & i_is_write & ~i_writable
                        & (~i_is_super | i_wpe);
        o_issue       = i_present & ~i_null_page & ~o_wr_denied;
    end
endmodule : lpwd_access_check
`default_nettype wire

// ### hdl/lpwd_entry_decode.sv
// Field extraction from one leaf or 2MB directory entry
`timescale 1ns/100ps
`default_nettype none
module lpwd_entry_decode import lpwd_pkg::*; #(
    parameter int unsigned CLIENT_HAW = HAW_CLIENT,
    parameter int unsigned SERVER_HAW = HAW_SERVER
) (
    input  wire logic [ENTRY_W-1:0] i_entry,
    input  wire logic [1:0]         i_page,
    input  wire logic               i_server,
    output logic      [PA_W-1:0]    o_base,
    output logic      [PA_W-1:0]    o_offset_mask,
    output logic                    o_present,
    output logic                    o_writable,
    output logic                    o_null_page,
    output logic      [2:0]         o_attr
);
    logic [PA_W-1:0] haw_mask;
    logic [PA_W-1:0] low_mask;

    always_comb begin
        haw_mask = i_server ? ~({PA_W{1'b1}} << SERVER_HAW) : ~({PA_W{1'b1}} << CLIENT_HAW);
        case (i_page)
            PG_64K:  low_mask = ~({PA_W{1'b1}} << SHIFT_64K);
            PG_2M:   low_mask = ~({PA_W{1'b1}} << SHIFT_2M);
            default: low_mask = ~({PA_W{1'b1}} << SHIFT_4K);
        endcase
        o_base        = i_entry[PA_W-1:0] & haw_mask & ~low_mask;
        o_offset_mask = low_mask;
        o_present     = i_entry[ENT_PRESENT];
        o_writable    = i_entry[ENT_RW];
        o_null_page   = i_entry[ENT_NULL];
        o_attr        = {i_entry[ENT_PAT], i_entry[ENT_PCD], i_entry[ENT_PWT]};
    end
endmodule : lpwd_entry_decode
`default_nettype wire

// ### hdl/lpwd_pkg.sv
// Shared constants and types for the leaf page entry walk decoder
// What this block does
// - The page base comes from entry bits 16 up for 64KB pages and 12 up for 4KB pages.
// - The physical address width is 39 (client) or 46 (server); entry bits above it are unused.
// - With nested translation enabled the entry address is marked as a guest physical address.
// - A null entry issues no memory access; reads return zero, writes are dropped.
// - A clear write bit denies user writes, and supervisor writes under write protection.
// - An entry maps a page only when its present bit is one.
// - Ignored entry bits never change the translation.
// - The memory type index comes from the attribute, cache-disable and write-through bits.
// - A 64KB page uses entry index address[20:16] followed by four zero bits.
// - The fifteen entries between two selected 64KB entries are never used.
// - A 2MB page skips the last table level; the directory entry gives the page base.
// - Only user-level contexts are expected; the supervisor path is kept but not relied on.
package lpwd_pkg;
    localparam int unsigned ENTRY_W    = 64;
    localparam int unsigned PA_W       = 46;
    localparam int unsigned VA_W       = 48;
    localparam int unsigned IDX_W      = 9;
    localparam int unsigned HAW_CLIENT = 39;
    localparam int unsigned HAW_SERVER = 46;

    localparam int unsigned SHIFT_4K   = 12;
    localparam int unsigned SHIFT_64K  = 16;
    localparam int unsigned SHIFT_2M   = 21;
    localparam int unsigned IDX_HI     = 20;
    localparam logic [3:0]  IDX_ZEROS  = 4'h0;

    localparam int unsigned ENT_PRESENT = 0;
    localparam int unsigned ENT_RW      = 1;
    localparam int unsigned ENT_PWT     = 3;
    localparam int unsigned ENT_PCD     = 4;
    localparam int unsigned ENT_PAT     = 7;
    localparam int unsigned ENT_NULL    = 9;

    localparam logic [5:0] REG_CTRL     = 6'h00;
    localparam logic [5:0] REG_ENTRY_LO = 6'h04;
    localparam logic [5:0] REG_ENTRY_HI = 6'h08;
    localparam logic [5:0] REG_VADDR_LO = 6'h0C;
    localparam logic [5:0] REG_VADDR_HI = 6'h10;
    localparam logic [5:0] REG_STATUS   = 6'h14;
    localparam logic [5:0] REG_PADDR_LO = 6'h18;
    localparam logic [5:0] REG_PADDR_HI = 6'h1C;
    localparam logic [5:0] REG_INDEX    = 6'h20;
    localparam logic [5:0] REG_DATA     = 6'h24;

    localparam int unsigned CTRL_START  = 0;
    localparam int unsigned CTRL_PAGE   = 1;
    localparam int unsigned CTRL_WRITE  = 3;
    localparam int unsigned CTRL_SUPER  = 4;
    localparam int unsigned CTRL_NESTED = 5;
    localparam int unsigned CTRL_WPE    = 6;
    localparam int unsigned CTRL_SERVER = 7;

    localparam int unsigned ST_BUSY     = 0;
    localparam int unsigned ST_DONE     = 1;
    localparam int unsigned ST_NOT_PRES = 2;
    localparam int unsigned ST_WR_DENY  = 3;
    localparam int unsigned ST_NULL     = 4;
    localparam int unsigned ST_ISSUED   = 5;
    localparam int unsigned ST_GPA      = 6;
    localparam int unsigned ST_ATTR     = 7;

    localparam logic [31:0] WORD_RESET  = 32'h0000_0000;

    typedef enum logic [1:0] {
        PG_4K  = 2'h0,
        PG_64K = 2'h1,
        PG_2M  = 2'h2
    } lpwd_page_e;

    typedef enum logic [2:0] {
        S_IDLE     = 3'h1,
        S_DECODE   = 3'h2,
        S_WAIT_MEM = 3'h4
    } lpwd_state_e;
endpackage : lpwd_pkg

// ### hdl/lpwd_walk_decoder.sv
// Leaf entry walk decoder top: register slave, decode sequence, memory request
//
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module lpwd_walk_decoder import lpwd_pkg::*; #(
    parameter int unsigned CLIENT_HAW = HAW_CLIENT,
    parameter int unsigned SERVER_HAW = HAW_SERVER
) (
    input  wire logic            i_clk,
    input  wire logic            i_reset_n,
    input  wire logic [5:0]      i_address,
    input  wire logic            i_read,
    input  wire logic            i_write,
    input  wire logic [31:0]     i_writedata,
    input  wire logic [3:0]      i_byteenable,
    output logic      [31:0]     o_readdata,
    output logic                 o_waitrequest,
    output logic                 o_mem_req,
    output logic      [PA_W-1:0] o_mem_addr,
    output logic                 o_mem_write,
    output logic      [31:0]     o_mem_wdata,
    output logic      [2:0]      o_mem_attr,
    output logic                 o_mem_gpa,
    input  wire logic            i_mem_ack,
    input  wire logic [31:0]     i_mem_rdata
);
    typedef struct packed {
        lpwd_state_e          state;
        logic                 waitreq;
        logic [31:0]          readdata;
        logic [1:0]           page;
        logic                 is_write;
        logic                 is_super;
        logic                 nested;
        logic                 supervisor_write_protect;
        logic                 server;
        logic [ENTRY_W-1:0]   entry;
        logic [VA_W-1:0]      vaddr;
        logic                 busy;
        logic                 done;
        logic                 not_present;
        logic                 wr_denied;
        logic                 null_cpl;
        logic                 issued;
        logic                 guest_phys_address;
        logic [2:0]           attr;
        logic [PA_W-1:0]      paddr;
        logic [IDX_W-1:0]     index;
        logic [31:0]          data;
        logic                 mem_req;
        logic [PA_W-1:0]      mem_addr;
        logic                 mem_write;
        logic [2:0]           mem_attr;
        logic                 mem_gpa;
    } lpwd_regs_s;

    lpwd_regs_s s;
    lpwd_regs_s next_s;

    logic [PA_W-1:0]  dec_base;
    logic [PA_W-1:0]  dec_offset_mask;
    logic             dec_present;
    logic             dec_writable;
    logic             dec_null_page;
    logic [2:0]       dec_attr;
    logic             chk_not_present;
    logic             chk_null_cpl;
    logic             chk_wr_denied;
    logic             chk_issue;
    logic [PA_W-1:0]  calc_paddr;
    logic [IDX_W-1:0] calc_index;
    logic [31:0]      rd_word;

    lpwd_entry_decode #(
        .CLIENT_HAW (CLIENT_HAW),
        .SERVER_HAW (SERVER_HAW)
    ) u_decode (
        .i_entry       (s.entry),
        .i_page        (s.page),
        .i_server      (s.server),
        .o_base        (dec_base),
        .o_offset_mask (dec_offset_mask),
        .o_present     (dec_present),
        .o_writable    (dec_writable),
        .o_null_page   (dec_null_page),
        .o_attr        (dec_attr)
    );

    lpwd_access_check u_check (
        .i_present     (dec_present),
        .i_writable    (dec_writable),
        .i_null_page   (dec_null_page),
        .i_is_write    (s.is_write),
        .i_is_super    (s.is_super),
        .i_wpe         (s.supervisor_write_protect),
        .o_not_present (chk_not_present),
        .o_null_cpl    (chk_null_cpl),
        .o_wr_denied   (chk_wr_denied),
        .o_issue       (chk_issue)
    );

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_word,
                                                input logic [31:0] new_word,
                                                input logic [3:0]  lanes);
        logic [31:0] result;
        result = old_word;
        for (int b = 0; b < 4; b++) begin
            if (lanes[b]) begin
                result[b*8 +: 8] = new_word[b*8 +: 8];
            end
        end
        return result;
    endfunction : merge_bytes

    always_comb begin
        calc_paddr = dec_base | (s.vaddr[PA_W-1:0] & dec_offset_mask);
        case (s.page)
            // every sixteenth entry; others never picked
            PG_64K:  calc_index = {s.vaddr[IDX_HI:SHIFT_64K], IDX_ZEROS};
            PG_2M:   calc_index = '0;
            default: calc_index = s.vaddr[IDX_HI:SHIFT_4K];
        endcase
    end

    always_comb begin
        rd_word = WORD_RESET;
        case (i_address)
            REG_CTRL: begin
                rd_word[CTRL_PAGE +: 2] = s.page;
                rd_word[CTRL_WRITE]     = s.is_write;
                rd_word[CTRL_SUPER]     = s.is_super;
                rd_word[CTRL_NESTED]    = s.nested;
                rd_word[CTRL_WPE]       = s.supervisor_write_protect;
                rd_word[CTRL_SERVER]    = s.server;
            end
            REG_ENTRY_LO: rd_word = s.entry[31:0];
            REG_ENTRY_HI: rd_word = s.entry[63:32];
            REG_VADDR_LO: rd_word = s.vaddr[31:0];
            REG_VADDR_HI: rd_word[VA_W-33:0] = s.vaddr[VA_W-1:32];
            REG_STATUS: begin
                rd_word[ST_BUSY]       = s.busy;
                rd_word[ST_DONE]       = s.done;
                rd_word[ST_NOT_PRES]   = s.not_present;
                rd_word[ST_WR_DENY]    = s.wr_denied;
                rd_word[ST_NULL]       = s.null_cpl;
                rd_word[ST_ISSUED]     = s.issued;
                rd_word[ST_GPA]        = s.guest_phys_address;
                rd_word[ST_ATTR +: 3]  = s.attr;
            end
            REG_PADDR_LO: rd_word = s.paddr[31:0];
            REG_PADDR_HI: rd_word[PA_W-33:0] = s.paddr[PA_W-1:32];
            REG_INDEX:    rd_word[IDX_W-1:0] = s.index;
            REG_DATA:     rd_word = s.data;
            default:      rd_word = WORD_RESET;
        endcase
    end

    always_comb begin
        next_s         = s;
        next_s.mem_req = 1'b0;

        // One wait cycle per access, then a single low cycle of waitrequest
        if (s.waitreq) begin
            if (i_read || i_write) begin
                next_s.waitreq  = 1'b0;
                next_s.readdata = rd_word;
            end
        end else begin
            next_s.waitreq = 1'b1;
        end

        case (s.state)
            S_IDLE: begin
                next_s.state = S_IDLE;
            end
            S_DECODE: begin
                next_s.not_present = chk_not_present;
                next_s.null_cpl    = chk_null_cpl;
                next_s.wr_denied   = chk_wr_denied;
                next_s.paddr       = calc_paddr;
                next_s.index       = calc_index;
                next_s.attr        = dec_attr;
                next_s.guest_phys_address         = s.nested;
                if (chk_issue) begin
                    next_s.mem_req   = 1'b1;
                    next_s.mem_addr  = calc_paddr;
                    next_s.mem_write = s.is_write;
                    next_s.mem_attr  = dec_attr;
                    next_s.mem_gpa   = s.nested;
                    next_s.issued    = 1'b1;
                    next_s.state     = S_WAIT_MEM;
                end else begin
                    if (chk_null_cpl && !s.is_write) begin
                        next_s.data = WORD_RESET;
                    end
                    next_s.busy  = 1'b0;
                    next_s.done  = 1'b1;
                    next_s.state = S_IDLE;
                end
            end
            S_WAIT_MEM: begin
                // Ack is looked at from the cycle of the request pulse onward
                if (i_mem_ack) begin
                    if (!s.mem_write) begin
                        next_s.data = i_mem_rdata;
                    end
                    next_s.busy  = 1'b0;
                    next_s.done  = 1'b1;
                    next_s.state = S_IDLE;
                end
            end
            default: begin
                next_s.state = S_IDLE;
                next_s.busy  = 1'b0;
            end
        endcase

        // A write takes effect only on the edge where waitrequest is seen low
        if (i_write && !s.waitreq) begin
            case (i_address)
                REG_CTRL: begin
                    // Settings are frozen while a decode is in flight
                    if (!s.busy) begin
                        if (i_byteenable[0]) begin
                            next_s.page     = i_writedata[CTRL_PAGE +: 2];
                            next_s.is_write = i_writedata[CTRL_WRITE];
                            next_s.is_super = i_writedata[CTRL_SUPER];
                            next_s.nested   = i_writedata[CTRL_NESTED];
                            next_s.supervisor_write_protect      = i_writedata[CTRL_WPE];
                            next_s.server   = i_writedata[CTRL_SERVER];
                        end
                        if (i_byteenable[0] && i_writedata[CTRL_START]) begin
                            next_s.state       = S_DECODE;
                            next_s.busy        = 1'b1;
                            next_s.done        = 1'b0;
                            next_s.issued      = 1'b0;
                            next_s.not_present = 1'b0;
                            next_s.wr_denied   = 1'b0;
                            next_s.null_cpl    = 1'b0;
                        end
                    end
                end
                REG_ENTRY_LO: begin
                    if (!s.busy) begin
                        next_s.entry[31:0] = merge_bytes(s.entry[31:0], i_writedata,
                                                         i_byteenable);
                    end
                end
                REG_ENTRY_HI: begin
                    if (!s.busy) begin
                        next_s.entry[63:32] = merge_bytes(s.entry[63:32], i_writedata,
                                                          i_byteenable);
                    end
                end
                REG_VADDR_LO: begin
                    if (!s.busy) begin
                        next_s.vaddr[31:0] = merge_bytes(s.vaddr[31:0], i_writedata,
                                                         i_byteenable);
                    end
                end
                REG_VADDR_HI: begin
                    if (!s.busy) begin
                        next_s.vaddr[VA_W-1:32] = 16'(merge_bytes({16'h0000, s.vaddr[VA_W-1:32]},
                                                              i_writedata,
                                                              i_byteenable));
                    end
                end
                REG_DATA: begin
                    if (!s.busy) begin
                        next_s.data = merge_bytes(s.data, i_writedata, i_byteenable);
                    end
                end
                default: begin
                    next_s.data = next_s.data;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s         <= '0;
            s.state   <= S_IDLE;
            s.waitreq <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign o_readdata    = s.readdata;
    assign o_waitrequest = s.waitreq;
    assign o_mem_req     = s.mem_req;
    assign o_mem_addr    = s.mem_addr;
    assign o_mem_write   = s.mem_write;
    assign o_mem_wdata   = s.data;
    assign o_mem_attr    = s.mem_attr;
    assign o_mem_gpa     = s.mem_gpa;
endmodule : lpwd_walk_decoder
`default_nettype wire

// ### testbench/lpwd_mem_model.sv
// Memory side model: answers each access after a chosen delay
`timescale 1ns/100ps
`default_nettype none
module lpwd_mem_model (
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic        i_req,
    input  wire logic [45:0] i_addr,
    input  wire logic [3:0]  i_delay,
    output logic             o_ack,
    output logic      [31:0] o_rdata
);
    logic       pend;
    logic [3:0] cnt;
    // Read data toggles outside the ack cycle so a stale capture shows up
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pend    <= 1'b0;
            cnt     <= 4'h0;
            o_ack   <= 1'b0;
            o_rdata <= 32'h0000_0000;
        end else begin
            o_ack   <= 1'b0;
            o_rdata <= ~o_rdata;
            if (i_req) begin
                pend <= 1'b1;
                cnt  <= i_delay;
            end else if (pend && cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end else if (pend) begin
                pend    <= 1'b0;
                o_ack   <= 1'b1;
                o_rdata <= i_addr[31:0] ^ 32'hA5A5_5A5A;
            end
        end
    end
endmodule : lpwd_mem_model
`default_nettype wire

// ### testbench/lpwd_walk_decoder_tb.sv
// Self-checking bench for the leaf page entry walk decoder
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin fails++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module lpwd_walk_decoder_tb import lpwd_pkg::*;;
    logic        clk, rst_n, rd, wr, wait_req, mem_req, mem_wr, mem_gpa, ack;
    logic [5:0]  addr;
    logic [31:0] wdata, rdata, mem_wdata, mem_rdata;
    logic [3:0]  be, dly;
    logic [45:0] mem_addr;
    logic [2:0]  mem_attr;
    int          fails, tests_run, reqs;
    lpwd_walk_decoder dut (.i_clk(clk), .i_reset_n(rst_n), .i_address(addr), .i_read(rd),
        .i_write(wr), .i_writedata(wdata), .i_byteenable(be), .o_readdata(rdata),
        .o_waitrequest(wait_req), .o_mem_req(mem_req), .o_mem_addr(mem_addr),
        .o_mem_write(mem_wr), .o_mem_wdata(mem_wdata), .o_mem_attr(mem_attr),
        .o_mem_gpa(mem_gpa), .i_mem_ack(ack), .i_mem_rdata(mem_rdata));
    lpwd_mem_model u_mem (.i_clk(clk), .i_reset_n(rst_n), .i_req(mem_req), .i_addr(mem_addr),
        .i_delay(dly), .o_ack(ack), .o_rdata(mem_rdata));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) if (mem_req === 1'b1) reqs++;
    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test
    // Holds the request until waitrequest is sampled low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do begin
            @(posedge clk);
        end while (wait_req !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    function automatic logic [45:0] exp_pa(logic [63:0] e, logic [47:0] v, logic [7:0] c);
        logic [45:0] lo, hi;
        lo = (c[2:1] == 2'h1) ? 46'h0000_FFFF : (c[2:1] == 2'h2) ? 46'h001F_FFFF : 46'h0FFF;
        hi = c[7] ? {46{1'b1}} : {7'h00, {39{1'b1}}};
        return (e[45:0] & hi & ~lo) | (v[45:0] & lo);
    endfunction : exp_pa
    // flags are {gpa, issued, null, denied, not present}
    task automatic walk(input logic [63:0] e, input logic [47:0] v, input logic [7:0] c,
                        input logic [4:0] f);
        logic [31:0] q, s, lo, hi;
        logic [45:0] pa;
        int n = 0;
        int r0 = reqs;
        pa = exp_pa(e, v, c);
        bus(1'b1, REG_ENTRY_LO, e[31:0], q);
        bus(1'b1, REG_ENTRY_HI, e[63:32], q);
        bus(1'b1, REG_VADDR_LO, v[31:0], q);
        bus(1'b1, REG_VADDR_HI, {16'h0000, v[47:32]}, q);
        bus(1'b1, REG_DATA, 32'hC0DE_0000 ^ v[31:0], q);
        bus(1'b1, REG_CTRL, {24'h00_0000, c | 8'h01}, q);
        do begin
            bus(1'b0, REG_STATUS, 32'h0000_0000, s);
            n++;
        end while (s[1] !== 1'b1 && n < 40);
        `CHK("status", {f, 2'b10}, s[6:0])
        `CHK("access count", int'(f[3]), reqs - r0)
        bus(1'b0, REG_DATA, 32'h0000_0000, q);
        if (f[3]) begin
            bus(1'b0, REG_PADDR_LO, 32'h0000_0000, lo);
            bus(1'b0, REG_PADDR_HI, 32'h0000_0000, hi);
            `CHK("paddr", pa, {hi[13:0], lo})
            `CHK("mem addr", pa, mem_addr)
            `CHK("attr", {e[7], e[4], e[3]}, mem_attr)
            `CHK("gpa", c[5], mem_gpa)
            `CHK("mem write", c[3], mem_wr)
            if (c[3]) `CHK("wdata", 32'hC0DE_0000 ^ v[31:0], mem_wdata)
            if (!c[3]) `CHK("read data", pa[31:0] ^ 32'hA5A5_5A5A, q)
        end else if (f[2] && !c[3]) begin
            `CHK("null data", 32'h0000_0000, q)
        end
    endtask : walk
    task automatic t_regs();
        logic [31:0] q;
        bus(1'b0, REG_STATUS, 32'h0000_0000, q);
        `CHK("status reset", WORD_RESET, q)
        bus(1'b1, 6'h3C, 32'hFFFF_FFFF, q);
        bus(1'b0, 6'h3C, 32'h0000_0000, q);
        `CHK("unmapped", 32'h0000_0000, q)
        $display("test regs done");
    endtask : t_regs
    // Ignored bits and bits above the client width must not move the address
    task automatic t_page4k();
        walk(64'hFFFF_FF12_3456_7DFF, 48'h1234_5678_9ABC, 8'h00, 5'b01000);
        walk(64'h0000_0012_3456_709B, 48'h1234_5678_9ABC, 8'h00, 5'b01000);
        walk(64'h0000_0012_3456_7003, 48'h0000_0000_0FFF, 8'h08, 5'b01000);
        $display("test page4k done");
    endtask : t_page4k
    task automatic t_page64k();
        logic [31:0] q;
        dly <= 4'h6;
        walk(64'hFFFF_2ABC_DEF5_FC01, 48'h7654_3217_ABCD, 8'hA2, 5'b11000);
        bus(1'b0, REG_INDEX, 32'h0000_0000, q);
        `CHK("index", {23'h00_0000, 5'h17, 4'h0}, q)
        dly <= 4'h0;
        $display("test page64k done");
    endtask : t_page64k
    task automatic t_page2m();
        logic [31:0] q;
        walk(64'h0000_0000_7FFF_FC83, 48'h0000_0ABC_DEF0, 8'h04, 5'b01000);
        bus(1'b0, REG_INDEX, 32'h0000_0000, q);
        `CHK("index 2m", 32'h0000_0000, q)
        $display("test page2m done");
    endtask : t_page2m
    // Refusals in priority order, then the supervisor write cases
    task automatic t_refuse();
        walk(64'h0000_0001_0000_0202, 48'h0000_0000_0123, 8'h00, 5'b00001);
        walk(64'h0000_0001_0000_0203, 48'h0000_0000_0123, 8'h00, 5'b00100);
        walk(64'h0000_0001_0000_0201, 48'h0000_0000_0123, 8'h08, 5'b00100);
        walk(64'h0000_0001_0000_0001, 48'h0000_0000_0123, 8'h08, 5'b00010);
        walk(64'h0000_0001_0000_0001, 48'h0000_0000_0123, 8'h58, 5'b00010);
        walk(64'h0000_0001_0000_0001, 48'h0000_0000_0123, 8'h18, 5'b01000);
        $display("test refuse done");
    endtask : t_refuse
    initial begin
        {rst_n, rd, wr, addr, wdata, dly} = '0;
        be = 4'hF;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_page4k();
        t_page64k();
        t_page2m();
        t_refuse();
        finish_test();
    end
    initial begin
        #100000;
        fails++;
        finish_test();
    end
endmodule : lpwd_walk_decoder_tb
bind lpwd_walk_decoder lpwd_walk_properties u_props (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_address(i_address), .i_write(i_write), .i_writedata(i_writedata),
    .o_waitrequest(o_waitrequest), .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr),
    .o_mem_write(o_mem_write), .o_mem_attr(o_mem_attr), .o_mem_gpa(o_mem_gpa));
`default_nettype wire

// ### testbench/lpwd_walk_properties.sv
// Port checker for the leaf page entry walk decoder
`timescale 1ns/100ps
`default_nettype none
module lpwd_walk_properties import lpwd_pkg::*; (
    input wire logic            i_clk,
    input wire logic            i_reset_n,
    input wire logic [5:0]      i_address,
    input wire logic            i_write,
    input wire logic [31:0]     i_writedata,
    input wire logic            o_waitrequest,
    input wire logic            o_mem_req,
    input wire logic [PA_W-1:0] o_mem_addr,
    input wire logic            o_mem_write,
    input wire logic [2:0]      o_mem_attr,
    input wire logic            o_mem_gpa
);
    logic [31:0] ent;
    logic [31:0] va;
    logic [7:0]  ctl;
    logic        commit;
    logic        start;
    logic [20:0] omask;
    assign commit = i_write && !o_waitrequest;
    assign start  = commit && (i_address == REG_CTRL) && i_writedata[0];
    assign omask  = (ctl[2:1] == 2'h1) ? 21'h00_FFFF :
                    (ctl[2:1] == 2'h2) ? 21'h1F_FFFF : 21'h00_0FFF;
    // Shadows follow committed writes only; the bench never writes while busy
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ent <= 32'h0000_0000;
            va  <= 32'h0000_0000;
            ctl <= 8'h00;
        end else if (commit) begin
            if (i_address == REG_ENTRY_LO) ent <= i_writedata;
            if (i_address == REG_VADDR_LO) va <= i_writedata;
            if (i_address == REG_CTRL) ctl <= i_writedata[7:0];
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    start_issue_a: assert property (start && ent[0] && !ent[9] && !i_writedata[3]
        |-> ##2 o_mem_req)
        else $error("present read entry gave no memory access");
    start_quiet_a: assert property (start && (!ent[0] || ent[9]) |=> !o_mem_req [*4])
        else $error("absent or null entry issued an access");
    write_deny_a: assert property (o_mem_req && o_mem_write && (!ctl[4] || ctl[6])
        |-> ent[1])
        else $error("write issued to a read-only page");
    attr_map_a: assert property (o_mem_req |-> o_mem_attr == {ent[7], ent[4], ent[3]})
        else $error("memory type bits differ from entry");
    gpa_flag_a: assert property (o_mem_req |-> o_mem_gpa == ctl[5])
        else $error("guest address flag differs from nested enable");
    base_4k_a: assert property (o_mem_req && ctl[2:1] == 2'h0
        |-> o_mem_addr[31:12] == ent[31:12])
        else $error("small page base differs from entry");
    width_clip_a: assert property (o_mem_req && !ctl[7] |-> o_mem_addr[45:39] == 7'h00)
        else $error("client address has bits above width");
    offset_keep_a: assert property (o_mem_req
        |-> (o_mem_addr[20:0] & omask) == (va[20:0] & omask))
        else $error("page offset not carried through");
    addr_stands_a: assert property (o_mem_req |=> $stable(o_mem_addr) [*3])
        else $error("memory address changed after request");
endmodule : lpwd_walk_properties
`default_nettype wire
